// [bench/test_adc_min_max_tracker.sv]
// self-checking bench for the adc min/max tracker top module
// assumes default parameters: eight channels, 12-bit codes, byte address = 4 * index
`default_nettype none
`include "ammt_map.svh"
module test_adc_min_max_tracker;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic conv_valid = 1'b0;
	logic [2:0] conv_chan = 3'h0;
	logic [11:0] conv_code = 12'h000;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int err_total = 0;
	int samples_checked = 0;

	ammt_top dut (.clk, .rst, .conv_valid, .conv_chan, .conv_code, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	// 100 mhz clock
	always #5 clk = ~clk;

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ready and valid are looked at on the falling edge, where they are settled
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] r);
		bit a = 0;
		bit w = 0;
		@(posedge clk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			a = a | (s_axi_awready === 1'b1);
			w = w | (s_axi_wready === 1'b1);
			@(posedge clk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!(a && w));
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		check(nm, d, {24'h000000, exp});
		check("read resp", {30'h0, r}, {30'h0, `AMMT_RESP_OKAY});
	endtask

	task automatic conv(input logic [2:0] ch, input logic [11:0] code);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_chan <= ch;
		conv_code <= code;
		@(posedge clk);
		conv_valid <= 1'b0;
	endtask

	task automatic t_reset();
		logic [7:0] idx [7] = '{8'h6E, 8'h6F, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84};
		for (int i = 0; i < 7; i++) begin
			rdchk("reset value", idx[i], i < 2 ? `AMMT_MAX_RESET : `AMMT_MIN_RESET);
		end
	endtask

	// smaller code after a larger one must not win
	task automatic t_max();
		conv(3'h7, 12'hA5C);
		conv(3'h7, 12'h3B1);
		conv(3'h6, 12'h9E7);
		rdchk("ch7 max lo", `AMMT_IDX_MAX7_LO, 8'h5C);
		rdchk("ch7 max lo cleared", `AMMT_IDX_MAX7_LO, `AMMT_MAX_RESET);
		rdchk("ch7 max hi", `AMMT_IDX_MAX7_HI, 8'h0A);
		rdchk("ch6 max hi", 8'h6D, 8'h09);
		conv(3'h7, 12'h0B7);
		rdchk("ch7 max after clear", `AMMT_IDX_MAX7_LO, 8'hB7);
	endtask

	task automatic t_min();
		conv(3'h0, 12'h8C3);
		conv(3'h0, 12'h4D2);
		conv(3'h0, 12'h6FF);
		conv(3'h1, 12'h123);
		conv(3'h2, 12'h0F0);
		rdchk("ch0 min lo", `AMMT_IDX_MIN0_LO, 8'hD2);
		rdchk("ch0 min hi", `AMMT_IDX_MIN0_HI, 8'h04);
		rdchk("ch0 min lo set", `AMMT_IDX_MIN0_LO, `AMMT_MIN_RESET);
		rdchk("ch1 min lo", `AMMT_IDX_MIN1_LO, 8'h23);
		rdchk("ch1 min hi", `AMMT_IDX_MIN1_HI, 8'h01);
		rdchk("ch2 min lo", `AMMT_IDX_MIN2_LO, 8'hF0);
		rdchk("ch2 min lo set", `AMMT_IDX_MIN2_LO, `AMMT_MIN_RESET);
	endtask

	// writes refused, unmapped read must not clear anything
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		conv(3'h7, 12'h345);
		wr(8'h6E, 32'h000000AA, r);
		check("write resp", {30'h0, r}, {30'h0, `AMMT_RESP_SLVERR});
		wr(8'h80, 32'h00000000, r);
		check("write resp min", {30'h0, r}, {30'h0, `AMMT_RESP_SLVERR});
		rdchk("ch7 lo after write", `AMMT_IDX_MAX7_LO, 8'h45);
		rdchk("ch0 lo after write", `AMMT_IDX_MIN0_LO, `AMMT_MIN_RESET);
		rd(8'h10, d, r);
		check("unmapped data", d, 32'h00000000);
		check("unmapped resp", {30'h0, r}, {30'h0, `AMMT_RESP_SLVERR});
		rdchk("ch7 hi kept", `AMMT_IDX_MAX7_HI, 8'h03);
	endtask

	// reset in mid-run restores the minimum trackers
	task automatic t_rerun();
		conv(3'h1, 12'h010);
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk("ch1 min after reset", `AMMT_IDX_MIN1_LO, `AMMT_MIN_RESET);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_max();
		t_min();
		t_bus();
		t_rerun();
		conclude();
	end

	// all scenarios take well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire

// [hw/ammt_map.svh]
// register map and reset values of the adc min/max tracker
// assumes byte registers reached one per aligned 32-bit word
`ifndef AMMT_MAP_SVH
`define AMMT_MAP_SVH
`define AMMT_MAX_BASE_IDX 8'h60
`define AMMT_MIN_BASE_IDX 8'h80
`define AMMT_IDX_MAX7_LO 8'h6E
`define AMMT_IDX_MAX7_HI 8'h6F
`define AMMT_IDX_MIN0_LO 8'h80
`define AMMT_IDX_MIN0_HI 8'h81
`define AMMT_IDX_MIN1_LO 8'h82
`define AMMT_IDX_MIN1_HI 8'h83
`define AMMT_IDX_MIN2_LO 8'h84
`define AMMT_MAX_RESET 8'h00
`define AMMT_MIN_RESET 8'hFF
`define AMMT_RESP_OKAY 2'h0
`define AMMT_RESP_SLVERR 2'h2
`endif

// [hw/ammt_pkg.sv]
// types shared by the tracker modules
// assumes nothing of its surroundings
`default_nettype none
package ammt_pkg;
	typedef logic [15:0] ammt_code_type;
	typedef enum logic [1:0] {AMMT_RD_IDLE, AMMT_RD_RESP} ammt_rd_state_type;
endpackage
`default_nettype wire

// [hw/ammt_rd_if.sv]
// read-clear strobe carrier between the bus slave and the trackers
// assumes one clock shared by both ends
`default_nettype none
interface ammt_rd_if #(parameter int NCH = 8);
	logic [NCH-1:0] clr_max_lo;
	logic [NCH-1:0] clr_max_hi;
	logic [NCH-1:0] clr_min_lo;
	logic [NCH-1:0] clr_min_hi;
	modport src (output clr_max_lo, output clr_max_hi, output clr_min_lo, output clr_min_hi);
	modport dst (input clr_max_lo, input clr_max_hi, input clr_min_lo, input clr_min_hi);
endinterface
`default_nettype wire

// [hw/ammt_top.sv]
// adc min/max tracker with an axi4-lite register slave
// assumes conversion results arrive synchronous to clk
`default_nettype none
`include "ammt_map.svh"
module ammt_top #(
	parameter int NCH = 8,
	parameter int CW = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_valid,
	input wire logic [$clog2(NCH)-1:0] conv_chan,
	input wire logic [CW-1:0] conv_code,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ammt_pkg::*;
	ammt_rd_if #(.NCH(NCH)) rd_if ();
	logic [NCH*16-1:0] max_flat;
	logic [NCH*16-1:0] min_flat;
	ammt_tracker #(.NCH(NCH), .CW(CW)) u_trk (
		.clk(clk),
		.rst(rst),
		.conv_valid(conv_valid),
		.conv_chan(conv_chan),
		.conv_code(conv_code),
		.rd(rd_if.dst),
		.max_flat(max_flat),
		.min_flat(min_flat)
	);
	// write side: everything is read-only, so writes are taken and answered slverr
	logic aw_got_r;
	logic w_got_r;
	logic bvalid_r;
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
		end else if (bvalid_r) begin
			if (s_axi_bready)
				bvalid_r <= 1'b0;
		end else if ((aw_got_r || s_axi_awvalid) && (w_got_r || s_axi_wvalid)) begin
			bvalid_r <= 1'b1; // contents untouched
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
		end else begin
			aw_got_r <= aw_got_r || s_axi_awvalid;
			w_got_r <= w_got_r || s_axi_wvalid;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = `AMMT_RESP_SLVERR;
	// read decode: byte index is word address; even index low byte, odd high
	ammt_rd_state_type st_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire logic [9:0] idx;
	wire logic [7:0] idx8;
	wire logic ar_take;
	wire logic is_max;
	wire logic is_min;
	wire logic [7:0] off;
	wire logic [$clog2(NCH)-1:0] ch;
	wire logic hi;
	wire logic [15:0] max_sel;
	wire logic [15:0] min_sel;
	wire logic [7:0] byte_sel;
	assign idx = s_axi_araddr[11:2];
	assign idx8 = idx[7:0];
	assign ar_take = s_axi_arvalid && (st_r == AMMT_RD_IDLE);
	assign is_max = (idx[9:8] == 2'h0) && (idx8 >= `AMMT_MAX_BASE_IDX)
		&& (idx8 < 8'(`AMMT_MAX_BASE_IDX + 2 * NCH));
	assign is_min = (idx[9:8] == 2'h0) && (idx8 >= `AMMT_MIN_BASE_IDX)
		&& (idx8 < 8'(`AMMT_MIN_BASE_IDX + 2 * NCH));
	assign off = is_max ? 8'(idx8 - `AMMT_MAX_BASE_IDX) : 8'(idx8 - `AMMT_MIN_BASE_IDX);
	assign ch = off[$clog2(NCH):1];
	assign hi = off[0];
	assign max_sel = max_flat[ch*16 +: 16];
	assign min_sel = min_flat[ch*16 +: 16];
	// high byte carries upper code bits
	assign byte_sel = is_max ? (hi ? max_sel[15:8] : max_sel[7:0])
		: (hi ? min_sel[15:8] : min_sel[7:0]);
	assign s_axi_arready = (st_r == AMMT_RD_IDLE);
	// clear strobes fire on the same edge that captures the data
	wire logic [NCH-1:0] sel_vec;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gen_clr
			assign sel_vec[g] = ar_take && (ch == ($clog2(NCH))'(g));
		end
	endgenerate
	// whole-vector drives keep one driver per interface signal
	assign rd_if.clr_max_lo = sel_vec & {NCH{is_max && !hi}};
	assign rd_if.clr_max_hi = sel_vec & {NCH{is_max && hi}};
	assign rd_if.clr_min_lo = sel_vec & {NCH{is_min && !hi}};
	assign rd_if.clr_min_hi = sel_vec & {NCH{is_min && hi}};
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= AMMT_RD_IDLE;
			rdata_r <= 32'h0;
			rresp_r <= `AMMT_RESP_OKAY;
		end else begin
			unique case (st_r)
				AMMT_RD_IDLE: begin
					if (s_axi_arvalid) begin
						st_r <= AMMT_RD_RESP;
						rdata_r <= (is_max || is_min) ? {24'h0, byte_sel} : 32'h0;
						rresp_r <= (is_max || is_min) ? `AMMT_RESP_OKAY : `AMMT_RESP_SLVERR;
					end
				end
				AMMT_RD_RESP: begin
					if (s_axi_rready)
						st_r <= AMMT_RD_IDLE;
				end
				default: st_r <= AMMT_RD_IDLE;
			endcase
		end
	end
	assign s_axi_rvalid = (st_r == AMMT_RD_RESP);
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// read of the ch7 max low byte clears it next cycle unless a code refills it
	property p_max_clear;
		@(posedge clk) disable iff (rst)
		(ar_take && idx8 == `AMMT_IDX_MAX7_LO && idx[9:8] == 2'h0 && !conv_valid)
			|=> (max_flat[7*16 +: 8] == 8'h00);
	endproperty
	a_max_clear: assert property (p_max_clear) else $error("max low not cleared");
	property p_min_set;
		@(posedge clk) disable iff (rst)
		(ar_take && idx8 == `AMMT_IDX_MIN0_HI && idx[9:8] == 2'h0 && !conv_valid)
			|=> (min_flat[15:8] == 8'hFF);
	endproperty
	a_min_set: assert property (p_min_set) else $error("min high not set");
	property p_max_grow;
		@(posedge clk) disable iff (rst)
		(conv_valid && 16'(conv_code) > max_flat[conv_chan*16 +: 16])
			|=> (max_flat[$past(conv_chan)*16 +: 16] == 16'($past(conv_code)));
	endproperty
	a_max_grow: assert property (p_max_grow) else $error("max missed code");
	property p_min_fall;
		@(posedge clk) disable iff (rst)
		(conv_valid && 16'(conv_code) < min_flat[conv_chan*16 +: 16])
			|=> (min_flat[$past(conv_chan)*16 +: 16] == 16'($past(conv_code)));
	endproperty
	a_min_fall: assert property (p_min_fall) else $error("min missed code");
	property p_rst_max;
		@(posedge clk) rst |=> (max_flat[7*16 +: 16] == 16'h0000);
	endproperty
	a_rst_max: assert property (p_rst_max) else $error("ch7 max reset");
	property p_rst_min0;
		@(posedge clk) rst |=> (min_flat[15:0] == 16'hFFFF);
	endproperty
	a_rst_min0: assert property (p_rst_min0) else $error("ch0 min reset");
	property p_rst_min12;
		@(posedge clk) rst |=> (min_flat[47:16] == 32'hFFFFFFFF);
	endproperty
	a_rst_min12: assert property (p_rst_min12) else $error("ch1/2 min reset");
	sequence s_idle_no_code;
		!conv_valid && !ar_take;
	endsequence
	property p_read_only;
		@(posedge clk) disable iff (rst)
		s_idle_no_code |=> (max_flat == $past(max_flat) && min_flat == $past(min_flat));
	endproperty
	a_read_only: assert property (p_read_only) else $error("tracker moved");
	property p_read_answer;
		@(posedge clk) disable iff (rst)
		ar_take |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("no read answer");
endmodule
`default_nettype wire

// [hw/ammt_tracker.sv]
// per-channel peak trackers, bytewise read-clear
// assumes a conversion result strobe with channel number, one per cycle at most
`default_nettype none
`include "ammt_map.svh"
module ammt_tracker #(
	parameter int NCH = 8,
	parameter int CW = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_valid,
	input wire logic [$clog2(NCH)-1:0] conv_chan,
	input wire logic [CW-1:0] conv_code,
	ammt_rd_if.dst rd,
	output logic [NCH*16-1:0] max_flat,
	output logic [NCH*16-1:0] min_flat
);
	import ammt_pkg::*;
	// one net per output so each slice has a single driver
	wire logic [NCH*16-1:0] max_w;
	wire logic [NCH*16-1:0] min_w;
	assign max_flat = max_w;
	assign min_flat = min_w;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gen_ch
			ammt_code_type max_r;
			ammt_code_type min_r;
			ammt_code_type max_nxt;
			ammt_code_type min_nxt;
			wire logic hit;
			wire ammt_code_type code;
			assign hit = conv_valid && (conv_chan == ($clog2(NCH))'(g));
			assign code = ammt_code_type'(conv_code);
			// a fresh code beats the read-clear so no sample is lost
			always_comb begin
				max_nxt = max_r;
				if (rd.clr_max_lo[g])
					max_nxt[7:0] = `AMMT_MAX_RESET;
				if (rd.clr_max_hi[g])
					max_nxt[15:8] = `AMMT_MAX_RESET;
				if (hit && code > max_nxt)
					max_nxt = code;
				min_nxt = min_r;
				if (rd.clr_min_lo[g])
					min_nxt[7:0] = `AMMT_MIN_RESET;
				if (rd.clr_min_hi[g])
					min_nxt[15:8] = `AMMT_MIN_RESET;
				if (hit && code < min_nxt)
					min_nxt = code;
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					max_r <= {`AMMT_MAX_RESET, `AMMT_MAX_RESET};
					min_r <= {`AMMT_MIN_RESET, `AMMT_MIN_RESET};
				end else begin
					max_r <= max_nxt;
					min_r <= min_nxt;
				end
			end
			assign max_w[g*16 +: 16] = max_r;
			assign min_w[g*16 +: 16] = min_r;
		end
	endgenerate
endmodule
`default_nettype wire
